// ==== src/ilos_top.sv ====
// interlock output supervisor: combinations, timers, commands, buzzer, indications
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ilos_params.svh"

module ilos_top import ilos_pkg::*; #(
    parameter int unsigned SEC_CYC = `ILOS_SEC_MS * `ILOS_CLK_KHZ,
    parameter int unsigned BUZZ_HALF_CYC = `ILOS_BUZZ_HALF_MS * `ILOS_CLK_KHZ
) (
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    output logic [31:0] O_HRDATA,
    // field side
    input wire logic [99:0] I_CTRL_EXPR,
    input wire logic [99:0] I_FEEDBACK,
    output logic [99:0] O_OUTPUT,
    // panel state and clock of day
    input wire logic I_FIRE_ALARM,
    input wire logic I_PRE_WARN,
    input wire logic I_FAULT_BUZZ,
    input wire logic I_OTHER_PEND,
    input wire logic [4:0] I_HOUR,
    input wire logic [5:0] I_MINUTE,
    input wire logic [3:0] I_MONTH,
    input wire logic [4:0] I_DAY,
    // indications
    output logic O_BUZZER,
    output logic [1:0] O_BUZZ_SRC,
    output logic O_INTERLOCK_IND,
    output logic O_DISABLE_LED,
    output logic [3:0] O_TRIG_CODES,
    output logic O_FAULT_EVENT
);
    localparam int N = `ILOS_COMBOS;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    ilos_cfg_t cfg [N];
    ilos_state_t state [N];
    logic [7:0] tcnt [N];
    logic [7:0] fcnt [N];
    logic manual [N];
    logic dis_s [N];
    logic dis_c [N];
    logic fault [N];
    logic fb_q [N];
    ilos_hhmm_t t_out [N];
    ilos_hhmm_t t_in [N];
    logic [N-1:0] fb_act, out_act, dis_any, fault_now, new_fb;

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [6:0] sel;
    logic cmd_v;
    logic [2:0] cmd_code;
    logic [6:0] cmd_area, cmd_point;
    logic silence;
    logic [31:0] next_rdata;
    logic addr_ok;
    logic [6:0] fl_area, fl_point;
    ilos_hhmm_t fl_time;
    logic [3:0] fl_month;
    logic [4:0] fl_day;
    logic fl_valid;
    logic buzz_req;
    ilos_hhmm_t now;

    assign now = '{hour: I_HOUR, minute: I_MINUTE};
    assign addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            O_HREADYOUT <= 1'b0;
            O_HRESP <= 1'b0;
        end else begin
            // zero wait states; always OKAY
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            dp_wr <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_wr <= addr_ok && I_HWRITE;
            dp_addr <= addr_ok ? I_HADDR[7:0] : 8'h00;
        end
    end

    always_comb begin
        next_rdata = `ILOS_RST_WORD;
        unique case (I_HADDR[7:0])
            `ILOS_A_SEL: next_rdata = {25'h0000000, sel};
            `ILOS_A_CFG: if (sel < 7'(N)) next_rdata = {7'h00, cfg[sel][40:16]};
            `ILOS_A_TIME: if (sel < 7'(N)) next_rdata = {16'h0000, cfg[sel][15:0]};
            `ILOS_A_STAT: if (sel < 7'(N)) begin
                next_rdata = {4'h0, state[sel] == ILOS_DELAY, dis_s[sel] | dis_c[sel],
                    manual[sel], fault[sel], fb_act[sel], out_act[sel],
                    t_in[sel], t_out[sel]};
            end
            `ILOS_A_GLOB: next_rdata = {26'h0000000, O_TRIG_CODES, buzz_req, O_BUZZER};
            `ILOS_A_FLT: next_rdata = {7'h00, fl_time, fl_point, fl_area};
            `ILOS_A_FLTD: next_rdata = {22'h000000, fl_valid, fl_day, fl_month};
            default: next_rdata = `ILOS_RST_WORD;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            O_HRDATA <= `ILOS_RST_WORD;
        end else if (addr_ok && !I_HWRITE) begin
            O_HRDATA <= next_rdata;
        end
    end

    // configuration written by the offline tool through SEL/CFG/TIME
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            sel <= 7'h00;
        end else if (dp_wr && dp_addr == `ILOS_A_SEL) begin
            sel <= I_HWDATA[6:0];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            for (int k = 0; k < N; k++) cfg[k] <= '0;
        end else if (dp_wr && sel < 7'(N)) begin
            if (dp_addr == `ILOS_A_CFG) cfg[sel][40:16] <= I_HWDATA[24:0];
            if (dp_addr == `ILOS_A_TIME) cfg[sel][15:0] <= I_HWDATA[15:0];
        end
    end

    // commands become a one-cycle pulse with area and point
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            cmd_v <= 1'b0;
            cmd_code <= 3'h0;
            cmd_area <= 7'h00;
            cmd_point <= 7'h00;
            silence <= 1'b0;
        end else begin
            cmd_v <= dp_wr && dp_addr == `ILOS_A_CMD;
            silence <= dp_wr && dp_addr == `ILOS_A_GLOB && I_HWDATA[0];
            if (dp_wr && dp_addr == `ILOS_A_CMD) begin
                cmd_code <= I_HWDATA[2:0];
                cmd_area <= I_HWDATA[14:8];
                cmd_point <= I_HWDATA[22:16];
            end
        end
    end

    // ----------------------------------------------------------------
    // one-second tick shared by all combinations
    // ----------------------------------------------------------------
    logic [31:0] sec_cnt;
    logic sec_tick;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            sec_cnt <= 32'h00000000;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= sec_cnt == SEC_CYC - 1;
            sec_cnt <= (sec_cnt == SEC_CYC - 1) ? 32'h00000000 : sec_cnt + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // combinations
    // ----------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_combo
        logic expr, cmd_hit, disabled, go_active, release_now;
        logic [7:0] flim;

        // a command other than collective disable and re-enable reaches only the combination with matching area and point
        assign cmd_hit = cmd_v && cfg[i].area == cmd_area
            && cfg[i].point == cmd_point && cmd_area != 7'h00 && cmd_point != 7'h00;
        assign fb_act[i] = I_FEEDBACK[i] && cfg[i].has_in
            && cfg[i].trig == `ILOS_TRIG_FEEDBACK;
        assign expr = I_CTRL_EXPR[i] && cfg[i].has_out;
        assign disabled = dis_s[i] || dis_c[i];
        assign dis_any[i] = disabled && cfg[i].has_out;
        assign out_act[i] = state[i] == ILOS_ACTIVE;
        assign new_fb[i] = fb_act[i] && !fb_q[i] && cfg[i].buzz_en;
        assign flim = (cfg[i].fault_s < `ILOS_FAULT_MIN_S) ? `ILOS_FAULT_MIN_S
            : cfg[i].fault_s;
        assign go_active = cmd_hit && cmd_code == `ILOS_CMD_ACT && cfg[i].has_out;
        // manual activation ignores latching; unlatched follows expression
        assign release_now = (cmd_hit && cmd_code == `ILOS_CMD_RST)
            || (!manual[i] && !cfg[i].latched && !expr);

        always_ff @(posedge I_CLOCK) begin
            if (!I_RESETN) begin
                dis_s[i] <= 1'b0;
                dis_c[i] <= 1'b0;
            end else begin
                if (cmd_hit && cmd_code == `ILOS_CMD_DIS) dis_s[i] <= 1'b1;
                else if (cmd_hit && cmd_code == `ILOS_CMD_ENA) dis_s[i] <= 1'b0;
                // collective re-enable clears only what the collective disable set
                if (cmd_v && cmd_code == `ILOS_CMD_CDIS) dis_c[i] <= cfg[i].has_out;
                else if (cmd_v && cmd_code == `ILOS_CMD_CENA) dis_c[i] <= 1'b0;
            end
        end

        always_ff @(posedge I_CLOCK) begin
            if (!I_RESETN) begin
                state[i] <= ILOS_IDLE;
                manual[i] <= 1'b0;
                tcnt[i] <= 8'h00;
            end else if (disabled) begin
                state[i] <= ILOS_IDLE;
                manual[i] <= 1'b0;
                tcnt[i] <= 8'h00;
            end else begin
                unique case (state[i])
                    ILOS_IDLE: begin
                        tcnt[i] <= 8'h00;
                        if (go_active) begin
                            state[i] <= ILOS_ACTIVE;
                            manual[i] <= 1'b1;
                        end else if (expr) begin
                            state[i] <= cfg[i].delayed ? ILOS_DELAY : ILOS_ACTIVE;
                        end
                    end
                    ILOS_DELAY: begin
                        if (go_active) begin
                            state[i] <= ILOS_ACTIVE;
                            manual[i] <= 1'b1;
                        end else if (!expr) begin
                            state[i] <= ILOS_IDLE;
                        end else if (tcnt[i] >= cfg[i].delay_s) begin
                            state[i] <= ILOS_ACTIVE;
                        end else if (sec_tick) begin
                            tcnt[i] <= tcnt[i] + 8'h01;
                        end
                    end
                    ILOS_ACTIVE: begin
                        if (go_active) begin
                            manual[i] <= 1'b1;
                        end else if (release_now) begin
                            state[i] <= ILOS_IDLE;
                            manual[i] <= 1'b0;
                        end
                    end
                endcase
            end
        end

        // feedback window opens only once the output is really on
        always_ff @(posedge I_CLOCK) begin
            if (!I_RESETN) begin
                fcnt[i] <= 8'h00;
                fault[i] <= 1'b0;
            end else if (state[i] != ILOS_ACTIVE || fb_act[i]) begin
                fcnt[i] <= 8'h00;
                if (state[i] != ILOS_ACTIVE) fault[i] <= 1'b0;
            end else if (cfg[i].fault_en && !fault[i]) begin
                if (fcnt[i] >= flim) fault[i] <= 1'b1;
                else if (sec_tick) fcnt[i] <= fcnt[i] + 8'h01;
            end
        end
        assign fault_now[i] = cfg[i].fault_en && !fault[i] && !fb_act[i]
            && state[i] == ILOS_ACTIVE && fcnt[i] >= flim;

        always_ff @(posedge I_CLOCK) begin
            if (!I_RESETN) begin
                fb_q[i] <= 1'b0;
                O_OUTPUT[i] <= 1'b0;
                t_out[i] <= '0;
                t_in[i] <= '0;
            end else begin
                fb_q[i] <= fb_act[i];
                O_OUTPUT[i] <= state[i] == ILOS_ACTIVE && !disabled;
                if (state[i] == ILOS_ACTIVE && !O_OUTPUT[i] && !disabled) t_out[i] <= now;
                if (fb_act[i] && !fb_q[i]) t_in[i] <= now;
            end
        end
    end

    // ----------------------------------------------------------------
    // fault record: lowest-numbered combination wins a tie
    // ----------------------------------------------------------------
    logic [6:0] next_fidx;
    always_comb begin
        next_fidx = 7'h00;
        for (int k = N - 1; k >= 0; k--) begin
            if (fault_now[k]) next_fidx = 7'(k);
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            fl_area <= 7'h00;
            fl_point <= 7'h00;
            fl_time <= '0;
            fl_month <= 4'h0;
            fl_day <= 5'h00;
            fl_valid <= 1'b0;
            O_FAULT_EVENT <= 1'b0;
        end else begin
            O_FAULT_EVENT <= |fault_now;
            if (|fault_now) begin
                fl_area <= cfg[next_fidx].area;
                fl_point <= cfg[next_fidx].point;
                fl_time <= now;
                fl_month <= I_MONTH;
                fl_day <= I_DAY;
                fl_valid <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // buzzer and indications
    // ----------------------------------------------------------------
    logic [31:0] bcnt;
    logic bphase;

    // a new feedback activation wins over a silence in the same cycle
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            buzz_req <= 1'b0;
        end else if (|new_fb) begin
            buzz_req <= 1'b1;
        end else if (silence) begin
            buzz_req <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN || !buzz_req || |new_fb) begin
            bcnt <= 32'h00000000;
            bphase <= 1'b1;
        end else if (bcnt == BUZZ_HALF_CYC - 1) begin
            bcnt <= 32'h00000000;
            bphase <= !bphase;
        end else begin
            bcnt <= bcnt + 32'h1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            O_BUZZER <= 1'b0;
            O_BUZZ_SRC <= 2'h0;
        end else if (I_FIRE_ALARM) begin
            O_BUZZER <= 1'b1;
            O_BUZZ_SRC <= 2'h3;
        end else if (I_PRE_WARN) begin
            O_BUZZER <= 1'b1;
            O_BUZZ_SRC <= 2'h2;
        end else if (buzz_req) begin
            O_BUZZER <= bphase;
            O_BUZZ_SRC <= 2'h1;
        end else begin
            O_BUZZER <= I_FAULT_BUZZ;
            O_BUZZ_SRC <= 2'h0;
        end
    end

    // indication stays low while fire, another indication or disablement is pending, and in the cycle a fault is detected
    always_ff @(posedge I_CLOCK) begin
        if (!I_RESETN) begin
            O_INTERLOCK_IND <= 1'b0;
            O_DISABLE_LED <= 1'b0;
            O_TRIG_CODES <= 4'h0;
        end else begin
            O_INTERLOCK_IND <= (|out_act || |fb_act) && !I_FIRE_ALARM
                && !I_OTHER_PEND && !(|fault_now) && !(|dis_any);
            O_DISABLE_LED <= |dis_any;
            O_TRIG_CODES <= {|dis_any, |fault_now | fl_valid, |out_act, |fb_act};
        end
    end
endmodule : ilos_top

// ==== common/ilos_params.svh ====
// offsets, command codes, reset values and timing figures of the interlock supervisor
`ifndef ILOS_PARAMS_SVH
`define ILOS_PARAMS_SVH
`define ILOS_COMBOS 100
`define ILOS_IDX_W 7
`define ILOS_TRIG_FEEDBACK 5'h0a
`define ILOS_FAULT_MIN_S 8'h05
`define ILOS_CLK_KHZ 200000
`define ILOS_SEC_MS 1000
`define ILOS_BUZZ_HALF_MS 800
// register byte addresses
`define ILOS_A_SEL 8'h00
`define ILOS_A_CFG 8'h04
`define ILOS_A_CMD 8'h08
`define ILOS_A_STAT 8'h0c
`define ILOS_A_GLOB 8'h10
`define ILOS_A_FLT 8'h14
`define ILOS_A_TIME 8'h18
`define ILOS_A_FLTD 8'h1c
// command codes in CMD[2:0]
`define ILOS_CMD_ACT 3'h1
`define ILOS_CMD_RST 3'h2
`define ILOS_CMD_DIS 3'h3
`define ILOS_CMD_ENA 3'h4
`define ILOS_CMD_CDIS 3'h5
`define ILOS_CMD_CENA 3'h6
`define ILOS_RST_WORD 32'h00000000
`endif

// ==== common/ilos_pkg.sv ====
// types of the interlock supervisor
package ilos_pkg;
    typedef struct packed {
        logic [6:0] area;
        logic [6:0] point;
        logic has_out;
        logic has_in;
        logic delayed;
        logic latched;
        logic buzz_en;
        logic fault_en;
        logic [4:0] trig;
        logic [7:0] delay_s;
        logic [7:0] fault_s;
    } ilos_cfg_t;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] minute;
    } ilos_hhmm_t;

    typedef enum logic [1:0] {
        ILOS_IDLE,
        ILOS_DELAY,
        ILOS_ACTIVE
    } ilos_state_t;
endpackage : ilos_pkg

// ==== verification/ilos_props.sv ====
// port checker of the interlock supervisor
`timescale 1ns/1ps
module ilos_props (
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    // bus
    input wire logic I_HSEL,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic I_HREADY,
    input wire logic O_HREADYOUT,
    input wire logic [31:0] O_HRDATA,
    // panel
    input wire logic I_FIRE_ALARM,
    input wire logic I_PRE_WARN,
    input wire logic I_OTHER_PEND,
    input wire logic O_BUZZER,
    input wire logic [1:0] O_BUZZ_SRC,
    input wire logic O_INTERLOCK_IND,
    input wire logic [3:0] O_TRIG_CODES,
    input wire logic O_FAULT_EVENT
);
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);
    wire rd_req = I_HSEL & I_HTRANS[1] & I_HREADY & ~I_HWRITE;
    // only the start of the on half is checked, silence may cut it later
    sequence s_buzz_on;
        O_BUZZER [*8];
    endsequence
    a_hready_wait: assert property ($past(I_RESETN) |-> O_HREADYOUT)
        else $error("hreadyout low outside reset");
    a_rdata_hold: assert property (!$past(rd_req) |-> $stable(O_HRDATA))
        else $error("read data moved without a read");
    a_ind_quiet: assert property ($past(I_OTHER_PEND) |-> !O_INTERLOCK_IND)
        else $error("interlock indication shown over pending indication");
    a_ind_cause: assert property (O_INTERLOCK_IND |-> (|O_TRIG_CODES[1:0])
        || $past(|O_TRIG_CODES[1:0])) else $error("interlock indication without activity");
    a_fire_first: assert property ($past(I_FIRE_ALARM) |-> O_BUZZ_SRC == 2'h3)
        else $error("fire alarm not top buzzer source");
    a_pre_second: assert property ($past(I_PRE_WARN && !I_FIRE_ALARM)
        |-> O_BUZZ_SRC == 2'h2) else $error("pre-warning not second buzzer source");
    a_fault_pulse: assert property (O_FAULT_EVENT |=> !O_FAULT_EVENT)
        else $error("fault event longer than one cycle");
    a_fault_code: assert property (O_FAULT_EVENT |-> ##[0:1] O_TRIG_CODES[2])
        else $error("fault event without fault code");
    a_buzz_half: assert property ($rose(O_BUZZER) && O_BUZZ_SRC == 2'h1
        && !I_FIRE_ALARM && !I_PRE_WARN |-> s_buzz_on) else $error("buzzer on half short");
endmodule : ilos_props

bind ilos_top ilos_props ilos_props_i (.I_CLOCK, .I_RESETN, .I_HSEL, .I_HTRANS, .I_HWRITE,
    .I_HREADY, .O_HREADYOUT, .O_HRDATA, .I_FIRE_ALARM, .I_PRE_WARN, .I_OTHER_PEND,
    .O_BUZZER, .O_BUZZ_SRC, .O_INTERLOCK_IND, .O_TRIG_CODES, .O_FAULT_EVENT);

// ==== verification/ilos_field.sv ====
// model of the controlled equipment that returns feedback
`timescale 1ns/1ps
module ilos_field #(
    parameter int LAT = 30
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // stimulus
    input wire logic [99:0] i_output,
    input wire logic [99:0] i_broken,
    input wire logic [99:0] i_force,
    // feedback
    output logic [99:0] o_feedback
);
    // ------------------------------------------------
    // feedback path
    // ------------------------------------------------
    // equipment reacts slowly, so the pipe is long compared to a bus cycle
    logic [99:0] pipe [LAT];
    always_ff @(posedge i_clock) begin
        pipe[0] <= i_resetn ? i_output : 100'h0;
        for (int k = 1; k < LAT; k++) begin
            pipe[k] <= i_resetn ? pipe[k-1] : 100'h0;
        end
    end
    // each feedback bit answers its own output only
    always_ff @(posedge i_clock) begin
        o_feedback <= (pipe[LAT-1] & ~i_broken) | i_force;
    end
endmodule : ilos_field

// ==== verification/testbench.sv ====
// self-checking bench of the interlock supervisor
`timescale 1ns/1ps
`include "ilos_params.svh"
`define TB_CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench import ilos_pkg::*;;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic fire = 1'b0, pre = 1'b0, fbuzz = 1'b0, pend = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [4:0] hour = 5'h0c;
    logic [3:0] month = 4'h7;
    logic [99:0] expr = 100'h0, broken = 100'h6, force_in = 100'h0;
    logic hreadyout, hresp, buzzer, ind, led, fevt;
    logic [31:0] hrdata;
    logic [99:0] outp, fb;
    logic [1:0] bsrc;
    logic [3:0] trig;
    int fails = 0, tests_run = 0, cyc = 0, nflt = 0;
    always #2.5 clk = ~clk;
    ilos_top #(.SEC_CYC(20), .BUZZ_HALF_CYC(16)) ilos_top_i (
        .I_CLOCK(clk), .I_RESETN(rstn), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hreadyout),
        .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .O_HRDATA(hrdata), .I_CTRL_EXPR(expr),
        .I_FEEDBACK(fb), .O_OUTPUT(outp), .I_FIRE_ALARM(fire), .I_PRE_WARN(pre),
        .I_FAULT_BUZZ(fbuzz), .I_OTHER_PEND(pend), .I_HOUR(hour), .I_MINUTE(6'h22),
        .I_MONTH(month), .I_DAY(5'h13), .O_BUZZER(buzzer), .O_BUZZ_SRC(bsrc),
        .O_INTERLOCK_IND(ind), .O_DISABLE_LED(led), .O_TRIG_CODES(trig), .O_FAULT_EVENT(fevt));
    ilos_field ilos_field_i (.i_clock(clk), .i_resetn(rstn), .i_output(outp),
        .i_broken(broken), .i_force(force_in), .o_feedback(fb));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task finish_test;
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc++;
        if (fevt === 1'b1) nflt++;
        if (cyc == 6000) begin
            fails++;
            finish_test();
        end
    end
    task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask : ahb
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr
    task automatic rdc(input logic [31:0] a, m, e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        `TB_CHK(r & m, e)
        // the slave never signals an error response
        `TB_CHK(hresp, 1'b0)
    endtask : rdc
    task automatic stat(input logic [6:0] i, input logic [31:0] m, e);
        wr(`ILOS_A_SEL, {25'h0, i});
        rdc(`ILOS_A_STAT, m, e);
    endtask : stat
    task automatic cmd(input logic [2:0] c, input logic [6:0] a, p);
        wr(`ILOS_A_CMD, {9'h000, p, 1'b0, a, 5'h00, c});
    endtask : cmd
    task automatic cfg(input logic [6:0] i, a, p, input logic [5:0] fl,
            input logic [4:0] tr, input logic [7:0] dl, ft);
        wr(`ILOS_A_SEL, {25'h0, i});
        // flag bits go out has_out first, as the slave packs them
        wr(`ILOS_A_CFG, {7'h00, a, p, fl[0], fl[1], fl[2], fl[3], fl[4], fl[5], tr});
        wr(`ILOS_A_TIME, {16'h0000, dl, ft});
    endtask : cfg
    task automatic wo(input int i, input logic v);
        for (int n = 0; n < 400 && outp[i] !== v; n++) @(posedge clk);
        `TB_CHK(outp[i], v)
    endtask : wo
    task automatic wflt;
        for (int n = 0; n < 400 && fevt !== 1'b1; n++) @(posedge clk);
    endtask : wflt
    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    initial begin
        int t0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        wr(`ILOS_A_SEL, 32'h64);
        rdc(`ILOS_A_CFG, 32'hffffffff, 32'h0);
        rdc(32'h20, 32'hffffffff, 32'h0);
        cfg(7'h00, 7'h01, 7'h01, 6'h33, `ILOS_TRIG_FEEDBACK, 8'h00, 8'h05);
        cfg(7'h01, 7'h63, 7'h63, 6'h2b, `ILOS_TRIG_FEEDBACK, 8'h00, 8'h05);
        cfg(7'h02, 7'h02, 7'h03, 6'h27, `ILOS_TRIG_FEEDBACK, 8'h03, 8'h06);
        cfg(7'h03, 7'h04, 7'h04, 6'h02, `ILOS_TRIG_FEEDBACK, 8'h00, 8'h05);
        cfg(7'h04, 7'h05, 7'h05, 6'h02, 5'h03, 8'h00, 8'h05);
        expr[0] <= 1'b1;
        wo(0, 1'b1);
        for (int n = 0; n < 100 && buzzer !== 1'b1; n++) @(posedge clk);
        `TB_CHK(buzzer, 1'b1)
        fbuzz <= 1'b1;
        repeat (2) @(posedge clk);
        `TB_CHK(bsrc, 2'h1)
        pre <= 1'b1;
        repeat (2) @(posedge clk);
        `TB_CHK(bsrc, 2'h2)
        fire <= 1'b1;
        repeat (2) @(posedge clk);
        `TB_CHK(bsrc, 2'h3)
        fire <= 1'b0;
        pre <= 1'b0;
        fbuzz <= 1'b0;
        wr(`ILOS_A_GLOB, 32'h1);
        repeat (3) @(posedge clk);
        `TB_CHK(buzzer, 1'b0)
        stat(7'h00, 32'h0fffffff, 32'h00d91322);
        `TB_CHK(trig[1:0], 2'h3)
        `TB_CHK(ind, 1'b1)
        pend <= 1'b1;
        repeat (2) @(posedge clk);
        `TB_CHK(ind, 1'b0)
        pend <= 1'b0;
        expr[0] <= 1'b0;
        wo(0, 1'b0);
        expr[0] <= 1'b1;
        wo(0, 1'b1);
        cmd(`ILOS_CMD_RST, 7'h01, 7'h01);
        wo(0, 1'b0);
        expr[0] <= 1'b0;
        hour <= 5'h0d;
        month <= 4'h8;
        expr[1] <= 1'b1;
        wo(1, 1'b1);
        expr[1] <= 1'b0;
        t0 = cyc;
        repeat (8) @(posedge clk);
        `TB_CHK(outp[1], 1'b1)
        wflt();
        `TB_CHK((cyc - t0 >= 75) && (cyc - t0 <= 150), 1'b1)
        rdc(`ILOS_A_FLT, 32'h01ffffff, 32'h00d8b1e3);
        rdc(`ILOS_A_FLTD, 32'h000003ff, 32'h00000338);
        `TB_CHK(trig[2], 1'b1)
        cmd(`ILOS_CMD_RST, 7'h63, 7'h63);
        wo(1, 1'b0);
        expr[2] <= 1'b1;
        t0 = cyc;
        repeat (4) @(posedge clk);
        stat(7'h02, 32'h08400000, 32'h08000000);
        wo(2, 1'b1);
        `TB_CHK((cyc - t0 >= 40) && (cyc - t0 <= 100), 1'b1)
        t0 = cyc;
        wflt();
        `TB_CHK((cyc - t0 >= 100) && (cyc - t0 <= 160), 1'b1)
        expr[2] <= 1'b0;
        wo(2, 1'b0);
        stat(7'h02, 32'h01000000, 32'h0);
        cmd(`ILOS_CMD_ACT, 7'h01, 7'h01);
        cmd(`ILOS_CMD_ACT, 7'h63, 7'h63);
        t0 = nflt;
        wo(0, 1'b1);
        wo(1, 1'b1);
        repeat (200) @(posedge clk);
        `TB_CHK(nflt - t0, 1)
        `TB_CHK(outp[0], 1'b1)
        cmd(`ILOS_CMD_RST, 7'h01, 7'h01);
        cmd(`ILOS_CMD_RST, 7'h63, 7'h63);
        wo(0, 1'b0);
        wo(1, 1'b0);
        expr[0] <= 1'b1;
        wo(0, 1'b1);
        cmd(`ILOS_CMD_DIS, 7'h01, 7'h01);
        wo(0, 1'b0);
        repeat (2) @(posedge clk);
        `TB_CHK(led, 1'b1)
        stat(7'h00, 32'h04000000, 32'h04000000);
        cmd(`ILOS_CMD_ENA, 7'h01, 7'h01);
        wo(0, 1'b1);
        cmd(`ILOS_CMD_CDIS, 7'h00, 7'h00);
        wo(0, 1'b0);
        `TB_CHK(led, 1'b1)
        cmd(`ILOS_CMD_CENA, 7'h00, 7'h00);
        wo(0, 1'b1);
        `TB_CHK(led, 1'b0)
        expr[0] <= 1'b0;
        force_in <= 100'h18;
        wo(0, 1'b0);
        stat(7'h03, 32'h00800000, 32'h00800000);
        stat(7'h04, 32'h00800000, 32'h0);
        `TB_CHK(trig[0], 1'b1)
        `TB_CHK(ind, 1'b1)
        finish_test();
    end
endmodule : testbench
